/* common/csf_pkg.sv */
// Constants and types for the CPU status flag unit
package csf_pkg;
  // Flag bit positions
  localparam int unsigned CARRY_POS = 7;
  localparam int unsigned ZERO_POS = 6;
  localparam int unsigned SIGN_POS = 5;
  localparam int unsigned OVFL_POS = 4;
  localparam int unsigned DECADJ_POS = 3;
  localparam int unsigned HALF_POS = 2;
  localparam int unsigned QUICK_POS = 1;
  localparam int unsigned BANK_POS = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // Register byte offsets on the bus
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h4;
  localparam logic [3:0] OFS_SHADOW = 4'h8;
  // BCD correction constants
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  // Operation codes presented at the end of an execute cycle
  typedef enum logic [4:0] {
    CSF_NOP = 5'h00,
    CSF_ADD = 5'h01,
    CSF_ADC = 5'h02,
    CSF_SUB = 5'h03,
    CSF_SBC = 5'h04,
    CSF_CP = 5'h05,
    CSF_INC = 5'h06,
    CSF_DEC = 5'h07,
    CSF_AND = 5'h08,
    CSF_OR = 5'h09,
    CSF_XOR = 5'h0A,
    CSF_COM = 5'h0B,
    CSF_RL = 5'h0C,
    CSF_RLC = 5'h0D,
    CSF_RR = 5'h0E,
    CSF_RRC = 5'h0F,
    CSF_SRA = 5'h10,
    CSF_TEST = 5'h11,
    CSF_SET_CARRY = 5'h12,
    CSF_CLEAR_CARRY = 5'h13,
    CSF_INVERT_CARRY = 5'h14,
    CSF_BCD_CORRECT = 5'h15,
    CSF_SELECT_BANK_ZERO = 5'h16,
    CSF_SELECT_BANK_ONE = 5'h17,
    CSF_INTERRUPT_RETURN = 5'h18,
    CSF_LOAD = 5'h19,
    CSF_QUICK_IRQ = 5'h1A
  } csf_op_e;
endpackage

/* logic/csf_flag_unit.sv */
// CPU status flag unit with Avalon-MM register access
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - Carry set on carry or borrow at bit 7
// - Rotate and shift load carry with bit out
// - Carry set, clear, invert leave other flags
// - Arithmetic and logic zero flag from result
// - Bit test and rotate zero flag from value
// - Sign flag copies result bit 7
// - Overflow on signed range; cleared by logic ops
// - Decimal flag records add or subtract
// - Half carry from bit 3 or borrow bit 4
// - Decimal adjust corrects using half and decimal
// - Only upper four flags drive jump conditions
// - Bit 1 quick interrupt, bit 0 bank
// - Loads write flag register as plain destination
// - Logic and arithmetic ops update their flags
// - Flag update and data write collision undefined
// - Quick interrupt sets bit; return clears it
// - Bank select ops clear or set bank bit
module csf_flag_unit (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic exec_valid_in,
  input csf_pkg::csf_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic dst_is_flags_in,
  input wire logic [3:0] cond_code_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [7:0] flags_out,
  output logic [7:0] result_out,
  output logic cond_true_out,
  output logic clash_out
);
  logic [7:0] flags;
  logic [7:0] shadow;
  logic [7:0] result;
  logic cond_true;
  logic clash;
  logic wait_q;
  logic [31:0] rdata;
  logic [7:0] next_flags;
  logic [7:0] next_shadow;
  logic [7:0] next_result;
  logic next_cond_true;
  logic next_clash;
  logic next_wait;
  logic [31:0] next_rdata;
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [4:0] add_lo;
  logic [4:0] sub_lo;
  logic cin;
  logic [7:0] fix;
  logic bus_go;

  // Jump condition from carry, zero, sign, overflow only
  function automatic logic cond_eval(input logic [3:0] cc,
                                     input logic [3:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    c = f[3];
    z = f[2];
    s = f[1];
    v = f[0];
    case (cc)
      4'h0: cond_eval = 1'b0;
      4'h1: cond_eval = s ^ v;
      4'h2: cond_eval = z | (s ^ v);
      4'h3: cond_eval = c | z;
      4'h4: cond_eval = v;
      4'h5: cond_eval = s;
      4'h6: cond_eval = z;
      4'h7: cond_eval = c;
      4'h8: cond_eval = 1'b1;
      4'h9: cond_eval = ~(s ^ v);
      4'hA: cond_eval = ~(z | (s ^ v));
      4'hB: cond_eval = ~(c | z);
      4'hC: cond_eval = ~v;
      4'hD: cond_eval = ~s;
      4'hE: cond_eval = ~z;
      default: cond_eval = ~c;
    endcase
  endfunction

  // Adders shared by the arithmetic group
  always_comb begin
    cin = ((op_in == csf_pkg::CSF_ADC) || (op_in == csf_pkg::CSF_SBC)) ?
          flags[csf_pkg::CARRY_POS] : 1'b0;
    add9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
    sub9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin};
    add_lo = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
    sub_lo = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, cin};
  end

  // Next flag, result and shadow values
  always_comb begin
    next_flags = flags;
    next_result = result;
    next_shadow = shadow;
    next_clash = 1'b0;
    fix = 8'h00;
    bus_go = (avs_read_in || avs_write_in) && !wait_q;
    // Bus write acts as a plain destination
    if (bus_go && avs_write_in && avs_address_in == csf_pkg::OFS_FLAGS) begin
      next_flags = avs_writedata_in[7:0];
    end
    if (exec_valid_in) begin
      case (op_in)
        csf_pkg::CSF_ADD, csf_pkg::CSF_ADC, csf_pkg::CSF_CP,
        csf_pkg::CSF_SUB, csf_pkg::CSF_SBC: begin
          if (op_in == csf_pkg::CSF_ADD || op_in == csf_pkg::CSF_ADC) begin
            next_result = add9[7:0];
            next_flags[csf_pkg::CARRY_POS] = add9[8];
            next_flags[csf_pkg::OVFL_POS] = (a_in[7] == b_in[7]) &&
                                            (add9[7] != a_in[7]);
            next_flags[csf_pkg::HALF_POS] = add_lo[4];
            next_flags[csf_pkg::DECADJ_POS] = 1'b0;
          end else begin
            next_result = sub9[7:0];
            next_flags[csf_pkg::CARRY_POS] = sub9[8];
            next_flags[csf_pkg::OVFL_POS] = (a_in[7] != b_in[7]) &&
                                            (sub9[7] != a_in[7]);
            if (op_in != csf_pkg::CSF_CP) begin
              next_flags[csf_pkg::HALF_POS] = sub_lo[4];
              next_flags[csf_pkg::DECADJ_POS] = 1'b1;
            end
          end
          if (op_in == csf_pkg::CSF_CP) begin
            next_result = result; // Compare keeps the result register
          end
          next_flags[csf_pkg::ZERO_POS] = (op_in == csf_pkg::CSF_CP) ?
              (sub9[7:0] == 8'h00) : (next_result == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = (op_in == csf_pkg::CSF_CP) ?
              sub9[7] : next_result[7];
        end
        csf_pkg::CSF_INC, csf_pkg::CSF_DEC: begin
          next_result = (op_in == csf_pkg::CSF_INC) ? a_in + 8'h01 :
                        a_in - 8'h01;
          next_flags[csf_pkg::ZERO_POS] = (next_result == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = next_result[7];
          next_flags[csf_pkg::OVFL_POS] = (op_in == csf_pkg::CSF_INC) ?
              (next_result == 8'h80) : (next_result == 8'h7F);
        end
        csf_pkg::CSF_AND, csf_pkg::CSF_OR, csf_pkg::CSF_XOR,
        csf_pkg::CSF_COM: begin
          case (op_in)
            csf_pkg::CSF_AND: next_result = a_in & b_in;
            csf_pkg::CSF_OR: next_result = a_in | b_in;
            csf_pkg::CSF_XOR: next_result = a_in ^ b_in;
            default: next_result = ~a_in;
          endcase
          next_flags[csf_pkg::ZERO_POS] = (next_result == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = next_result[7];
          next_flags[csf_pkg::OVFL_POS] = 1'b0;
        end
        csf_pkg::CSF_RL, csf_pkg::CSF_RLC, csf_pkg::CSF_RR,
        csf_pkg::CSF_RRC, csf_pkg::CSF_SRA: begin
          case (op_in)
            csf_pkg::CSF_RL: next_result = {a_in[6:0], a_in[7]};
            csf_pkg::CSF_RLC: next_result = {a_in[6:0],
                                             flags[csf_pkg::CARRY_POS]};
            csf_pkg::CSF_RR: next_result = {a_in[0], a_in[7:1]};
            csf_pkg::CSF_RRC: next_result = {flags[csf_pkg::CARRY_POS],
                                             a_in[7:1]};
            default: next_result = {a_in[7], a_in[7:1]};
          endcase
          next_flags[csf_pkg::CARRY_POS] = (op_in == csf_pkg::CSF_RL ||
              op_in == csf_pkg::CSF_RLC) ? a_in[7] : a_in[0];
          next_flags[csf_pkg::ZERO_POS] = (next_result == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = next_result[7];
          next_flags[csf_pkg::OVFL_POS] = (op_in == csf_pkg::CSF_SRA) ?
              1'b0 : (next_result[7] ^ a_in[7]);
        end
        csf_pkg::CSF_TEST: begin
          next_flags[csf_pkg::ZERO_POS] = ((a_in & b_in) == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = a_in[7] & b_in[7];
          next_flags[csf_pkg::OVFL_POS] = 1'b0;
        end
        csf_pkg::CSF_SET_CARRY: next_flags[csf_pkg::CARRY_POS] = 1'b1;
        csf_pkg::CSF_CLEAR_CARRY: begin
          next_flags[csf_pkg::CARRY_POS] = 1'b0;
        end
        csf_pkg::CSF_INVERT_CARRY: begin
          next_flags[csf_pkg::CARRY_POS] = ~flags[csf_pkg::CARRY_POS];
        end
        csf_pkg::CSF_BCD_CORRECT: begin
          // Correction direction chosen by the decimal flag
          if (!flags[csf_pkg::DECADJ_POS]) begin
            if (flags[csf_pkg::HALF_POS] ||
                a_in[3:0] > csf_pkg::BCD_DIGIT_MAX) begin
              fix = fix | csf_pkg::BCD_LOW_FIX;
            end
            if (flags[csf_pkg::CARRY_POS] || a_in > csf_pkg::BCD_BYTE_MAX) begin
              fix = fix | csf_pkg::BCD_HIGH_FIX;
              next_flags[csf_pkg::CARRY_POS] = 1'b1;
            end
            next_result = a_in + fix;
          end else begin
            if (flags[csf_pkg::HALF_POS]) begin
              fix = fix | csf_pkg::BCD_LOW_FIX;
            end
            if (flags[csf_pkg::CARRY_POS]) begin
              fix = fix | csf_pkg::BCD_HIGH_FIX;
            end
            next_result = a_in - fix;
          end
          next_flags[csf_pkg::ZERO_POS] = (next_result == 8'h00);
          next_flags[csf_pkg::SIGN_POS] = next_result[7];
        end
        csf_pkg::CSF_SELECT_BANK_ZERO: begin
          next_flags[csf_pkg::BANK_POS] = 1'b0;
        end
        csf_pkg::CSF_SELECT_BANK_ONE: begin
          next_flags[csf_pkg::BANK_POS] = 1'b1;
        end
        csf_pkg::CSF_QUICK_IRQ: begin
          next_shadow = flags;
          next_flags[csf_pkg::QUICK_POS] = 1'b1;
        end
        csf_pkg::CSF_INTERRUPT_RETURN: begin
          // Quick return restores the shadow, else the popped byte
          next_flags = flags[csf_pkg::QUICK_POS] ? shadow : b_in;
          next_flags[csf_pkg::QUICK_POS] = 1'b0;
        end
        csf_pkg::CSF_LOAD: next_flags = b_in;
        default: next_flags = next_flags;
      endcase
      // Flag-affecting op naming this register: raise clash_out
      if (dst_is_flags_in && op_in != csf_pkg::CSF_LOAD &&
          op_in != csf_pkg::CSF_NOP) begin
        next_clash = 1'b1;
      end
    end
    next_cond_true = cond_eval(cond_code_in,
                               flags[csf_pkg::CARRY_POS:csf_pkg::OVFL_POS]);
  end

  // Bus slave answer: one wait cycle, then a one-cycle acceptance
  always_comb begin
    next_wait = !((avs_read_in || avs_write_in) && wait_q);
    next_rdata = rdata;
    if ((avs_read_in || avs_write_in) && wait_q) begin
      case (avs_address_in)
        csf_pkg::OFS_FLAGS: next_rdata = {24'h000000, flags};
        csf_pkg::OFS_RESULT: next_rdata = {24'h000000, result};
        csf_pkg::OFS_SHADOW: next_rdata = {24'h000000, shadow};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags <= csf_pkg::FLAGS_RESET;
      shadow <= csf_pkg::FLAGS_RESET;
      result <= csf_pkg::RESULT_RESET;
      cond_true <= 1'b0;
      clash <= 1'b0;
      wait_q <= 1'b1;
      rdata <= 32'h00000000;
    end else begin
      flags <= next_flags;
      shadow <= next_shadow;
      result <= next_result;
      cond_true <= next_cond_true;
      clash <= next_clash;
      wait_q <= next_wait;
      rdata <= next_rdata;
    end
  end

  assign flags_out = flags;
  assign result_out = result;
  assign cond_true_out = cond_true;
  assign clash_out = clash;
  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata;

  AST_ADD_CARRY: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_ADD |=>
    flags_out[7] == (({1'b0, $past(a_in)} + {1'b0, $past(b_in)}) > 9'h0FF))
    else $error("carry after add wrong");
  AST_ROT_CARRY: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_RL |=>
    flags_out[7] == $past(a_in[7]) && result_out[0] == $past(a_in[7]))
    else $error("rotate carry wrong");
  AST_SET_CARRY: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_SET_CARRY |=>
    flags_out[7] && flags_out[6:0] == $past(flags_out[6:0]))
    else $error("set carry disturbed flags");
  AST_ZERO_SIGN: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in inside {csf_pkg::CSF_ADD, csf_pkg::CSF_XOR} |=>
    flags_out[6] == (result_out == 8'h00) && flags_out[5] == result_out[7])
    else $error("zero or sign flag wrong");
  AST_LOGIC_OVFL: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_OR |=> !flags_out[4])
    else $error("overflow not cleared by logic op");
  AST_DECADJ: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_SUB |=> flags_out[3])
    else $error("decimal flag not set by subtract");
  AST_QUICK: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_INTERRUPT_RETURN && flags_out[1] |=>
    !flags_out[1] && flags_out[7:2] == $past(shadow[7:2]) &&
    flags_out[0] == $past(shadow[0]))
    else $error("quick return did not restore flags");
  AST_BANK: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    exec_valid_in && op_in == csf_pkg::CSF_SELECT_BANK_ONE |=> flags_out[0])
    else $error("bank bit not set");
  AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !exec_valid_in && !avs_write_in |=> $stable(flags_out))
    else $error("flags changed without cause");
  AST_BUS_ACK: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    avs_write_in && avs_waitrequest_out |=> !avs_waitrequest_out ##1
    avs_waitrequest_out)
    else $error("bus answer timing wrong");
endmodule

/* tb/csf_flag_unit_tb_top.sv */
// Self-checking testbench for the CPU status flag unit
`timescale 1ns/1ps
module csf_flag_unit_tb_top;
  logic sys_clk_in;
  logic resetn_in;
  logic exec_valid_in;
  csf_pkg::csf_op_e op_in;
  logic [7:0] a_in;
  logic [7:0] b_in;
  logic dst_is_flags_in;
  logic [3:0] cond_code_in;
  logic [3:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] flags_out;
  logic [7:0] result_out;
  logic cond_true_out;
  logic clash_out;
  int bad_count;
  int num_checks;
  logic [31:0] rd;
  logic [15:0] cond_exp;

  // Device under test
  csf_flag_unit csf_flag_unit_i (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .exec_valid_in(exec_valid_in),
    .op_in(op_in),
    .a_in(a_in),
    .b_in(b_in),
    .dst_is_flags_in(dst_is_flags_in),
    .cond_code_in(cond_code_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .flags_out(flags_out),
    .result_out(result_out),
    .cond_true_out(cond_true_out),
    .clash_out(clash_out)
  );

  // 40 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [3:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge sys_clk_in);
    avs_address_in <= addr;
    avs_writedata_in <= wdata;
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    // Only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rdata = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // Let a landed write settle before callers look at the flags
    #1;
  endtask

  // One end-of-execute strobe; outputs settled on return
  task automatic exec_op(input csf_pkg::csf_op_e op, input logic [7:0] a,
                         input logic [7:0] b, input logic dst);
    @(posedge sys_clk_in);
    exec_valid_in <= 1'b1;
    op_in <= op;
    a_in <= a;
    b_in <= b;
    dst_is_flags_in <= dst;
    @(posedge sys_clk_in);
    exec_valid_in <= 1'b0;
    dst_is_flags_in <= 1'b0;
    #1;
  endtask

  // Execute then compare the whole flag byte
  task automatic ef(input csf_pkg::csf_op_e op, input logic [7:0] a,
                    input logic [7:0] b, input logic [7:0] exp);
    exec_op(op, a, b, 1'b0);
    check(32'(flags_out), 32'(exp));
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(25 * 5000);
    bad_count++;
    final_report();
  end

  // Main test sequence
  initial begin
    resetn_in = 1'b0;
    exec_valid_in = 1'b0;
    op_in = csf_pkg::CSF_NOP;
    a_in = 8'h00;
    b_in = 8'h00;
    dst_is_flags_in = 1'b0;
    cond_code_in = 4'h0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    bad_count = 0;
    num_checks = 0;
    cond_exp = 16'h51AE;
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    bus_xfer(1'b0, csf_pkg::OFS_FLAGS, 32'h0, rd);
    check(rd, 32'h00000000);
    ef(csf_pkg::CSF_LOAD, 8'h00, 8'hA5, 8'hA5);
    bus_xfer(1'b1, csf_pkg::OFS_FLAGS, 32'h00000000, rd);
    check(32'(flags_out), 32'h00000000);
    $display("test reset_and_load done");
    // Arithmetic and logic flag updates
    ef(csf_pkg::CSF_ADD, 8'hFF, 8'h01, 8'hC4);
    check(32'(result_out), 32'h00000000);
    ef(csf_pkg::CSF_ADD, 8'h7F, 8'h01, 8'h34);
    check(32'(result_out), 32'h00000080);
    ef(csf_pkg::CSF_SUB, 8'h00, 8'h01, 8'hAC);
    ef(csf_pkg::CSF_AND, 8'hF0, 8'h0F, 8'hCC);
    $display("test arithmetic done");
    // Carry force, clear and invert
    ef(csf_pkg::CSF_CLEAR_CARRY, 8'h00, 8'h00, 8'h4C);
    ef(csf_pkg::CSF_INVERT_CARRY, 8'h00, 8'h00, 8'hCC);
    ef(csf_pkg::CSF_CLEAR_CARRY, 8'h00, 8'h00, 8'h4C);
    ef(csf_pkg::CSF_SET_CARRY, 8'h00, 8'h00, 8'hCC);
    $display("test carry_ops done");
    // Rotate, shift and bit test
    ef(csf_pkg::CSF_RL, 8'h80, 8'h00, 8'h9C);
    check(32'(result_out), 32'h00000001);
    ef(csf_pkg::CSF_RR, 8'h01, 8'h00, 8'hBC);
    ef(csf_pkg::CSF_SRA, 8'h01, 8'h00, 8'hCC);
    ef(csf_pkg::CSF_TEST, 8'h8F, 8'h81, 8'hAC);
    ef(csf_pkg::CSF_TEST, 8'h0F, 8'hF0, 8'hCC);
    $display("test rotate_test done");
    // Bank select and quick interrupt round trip
    ef(csf_pkg::CSF_SELECT_BANK_ONE, 8'h00, 8'h00, 8'hCD);
    ef(csf_pkg::CSF_SELECT_BANK_ZERO, 8'h00, 8'h00, 8'hCC);
    ef(csf_pkg::CSF_SELECT_BANK_ONE, 8'h00, 8'h00, 8'hCD);
    ef(csf_pkg::CSF_QUICK_IRQ, 8'h00, 8'h00, 8'hCF);
    bus_xfer(1'b0, csf_pkg::OFS_SHADOW, 32'h0, rd);
    check(rd, 32'h000000CD);
    ef(csf_pkg::CSF_ADD, 8'h01, 8'h01, 8'h03);
    ef(csf_pkg::CSF_INTERRUPT_RETURN, 8'h00, 8'h00, 8'hCD);
    ef(csf_pkg::CSF_INTERRUPT_RETURN, 8'h00, 8'h57, 8'h55);
    $display("test bank_quick done");
    // Decimal correction after add and subtract
    ef(csf_pkg::CSF_ADD, 8'h09, 8'h09, 8'h05);
    exec_op(csf_pkg::CSF_BCD_CORRECT, 8'h12, 8'h00, 1'b0);
    check(32'(result_out), 32'h00000018);
    check(32'(flags_out[7]), 32'h00000000);
    ef(csf_pkg::CSF_ADD, 8'h90, 8'h90, 8'h91);
    exec_op(csf_pkg::CSF_BCD_CORRECT, 8'h20, 8'h00, 1'b0);
    check(32'(result_out), 32'h00000080);
    check(32'(flags_out[7]), 32'h00000001);
    ef(csf_pkg::CSF_SUB, 8'h10, 8'h01, 8'h0D);
    exec_op(csf_pkg::CSF_BCD_CORRECT, 8'h0F, 8'h00, 1'b0);
    check(32'(result_out), 32'h00000009);
    $display("test decimal done");
    // Remaining arithmetic, logic and rotate codes
    ef(csf_pkg::CSF_LOAD, 8'h00, 8'h80, 8'h80);
    ef(csf_pkg::CSF_ADC, 8'h0F, 8'h00, 8'h04);
    check(32'(result_out), 32'h00000010);
    ef(csf_pkg::CSF_SET_CARRY, 8'h00, 8'h00, 8'h84);
    ef(csf_pkg::CSF_SBC, 8'h10, 8'h01, 8'h0C);
    check(32'(result_out), 32'h0000000E);
    ef(csf_pkg::CSF_CP, 8'h05, 8'h05, 8'h4C);
    check(32'(result_out), 32'h0000000E);
    ef(csf_pkg::CSF_INC, 8'h7F, 8'h00, 8'h3C);
    check(32'(result_out), 32'h00000080);
    ef(csf_pkg::CSF_DEC, 8'h80, 8'h00, 8'h1C);
    ef(csf_pkg::CSF_OR, 8'h00, 8'h00, 8'h4C);
    ef(csf_pkg::CSF_XOR, 8'hFF, 8'h0F, 8'h2C);
    ef(csf_pkg::CSF_COM, 8'h55, 8'h00, 8'h2C);
    check(32'(result_out), 32'h000000AA);
    ef(csf_pkg::CSF_SET_CARRY, 8'h00, 8'h00, 8'hAC);
    ef(csf_pkg::CSF_RLC, 8'h40, 8'h00, 8'h3C);
    check(32'(result_out), 32'h00000081);
    ef(csf_pkg::CSF_RRC, 8'h01, 8'h00, 8'hCC);
    check(32'(result_out), 32'h00000000);
    ef(csf_pkg::CSF_NOP, 8'h00, 8'h00, 8'hCC);
    $display("test other_ops done");
    // Every jump condition code against fixed flags
    ef(csf_pkg::CSF_LOAD, 8'h00, 8'hAC, 8'hAC);
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_in);
      cond_code_in <= 4'(i);
      repeat (2) @(posedge sys_clk_in);
      #1;
      check(32'(cond_true_out), 32'(cond_exp[i]));
    end
    $display("test conditions done");
    // Flag-affecting op aimed at the flag register
    exec_op(csf_pkg::CSF_ADD, 8'h01, 8'h01, 1'b1);
    check(32'(clash_out), 32'h00000001);
    exec_op(csf_pkg::CSF_ADD, 8'h01, 8'h01, 1'b0);
    check(32'(clash_out), 32'h00000000);
    $display("test clash done");
    // Register map through the bus
    bus_xfer(1'b1, csf_pkg::OFS_FLAGS, 32'h0000005A, rd);
    bus_xfer(1'b0, csf_pkg::OFS_FLAGS, 32'h0, rd);
    check(rd, 32'h0000005A);
    bus_xfer(1'b1, csf_pkg::OFS_RESULT, 32'h000000FF, rd);
    bus_xfer(1'b0, csf_pkg::OFS_RESULT, 32'h0, rd);
    check(rd, 32'h00000002);
    bus_xfer(1'b0, 4'hC, 32'h0, rd);
    check(rd, 32'h00000000);
    $display("test bus_map done");
    final_report();
  end
endmodule
